/* File: src/rfc_pkg.sv */
// constants and types shared by the repeat and flag-clear execution block
package rfc_pkg;
	// instruction word layout
	localparam int INSTR_W = 16;
	localparam int COUNT_W = 8;
	localparam logic [7:0] OPC_REPEAT_MEM = 8'h4B;
	localparam logic [7:0] OPC_REPEAT_IMM = 8'hCB;
	localparam logic [15:0] OPC_CLEAR_TC = 16'hCE32;
	localparam logic [15:0] OPC_CLEAR_TXM = 16'hCE20;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 8'h01;
	localparam logic TC_RESET = 1'b0;
	localparam logic TXM_RESET = 1'b0;
	// sequencer states
	typedef enum logic [1:0] {RFC_IDLE, RFC_ARMED, RFC_REPEAT} rfc_state_t;
endpackage

/* File: src/rfc_reset_sync.sv */
// two-stage release synchroniser for the device reset
`timescale 1ns/100ps
`default_nettype none
module rfc_reset_sync
(
	// clock and raw reset
	input wire logic refClk,
	input wire logic rawReset_n,
	// synchronised reset
	output logic syncReset_n
);
	logic stage1_reg;
	// assert at once, release after two edges
	always_ff @(posedge refClk or negedge rawReset_n)
	begin
		if (!rawReset_n)
		begin
			stage1_reg <= 1'b0;
			syncReset_n <= 1'b0;
		end
		else
		begin
			stage1_reg <= 1'b1;
			syncReset_n <= stage1_reg;
		end
	end
endmodule
`default_nettype wire

/* File: src/rfc_exec.sv */
// repeat counter, interrupt hold-off and status flag clears
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - memory repeat loads low eight bits of data word into counter.
// - next repeatable instruction executes counter value plus one times.
// - interrupts held off until all repetitions of next instruction finish.
// - device reset clears the iteration counter to zero.
// - clear-test-flag instruction forces the test/control flag to zero.
// - clear-transmit-mode clears framing mode; frame sync pin becomes input.
module rfc_exec
	import rfc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// instruction stream: one pulse per instruction issued by the core
	input wire logic instrValid,
	input wire logic [INSTR_W-1:0] instrWord,
	input wire logic instrRepeatable,
	// data memory operand for the memory repeat form
	input wire logic [INSTR_W-1:0] memOperand,
	// flag set paths from other instructions
	input wire logic tcSet,
	input wire logic txmSet,
	// outputs
	output logic [COUNT_W-1:0] iteration_count_reg,
	output logic reissue_reg,
	output logic intMask_reg,
	output logic test_control_flag,
	output logic transmit_framing_mode_bit,
	output logic fsxOutEn_n_reg
);
	logic rstSync_n;
	rfc_state_t state_reg;
	logic isRepMem;
	logic isRepImm;
	logic [COUNT_W-1:0] loadValue;

	rfc_reset_sync uResetSync
	(
		.refClk(ref_clk),
		.rawReset_n(reset_n),
		.syncReset_n(rstSync_n)
	);

	// opcode decode, used by several processes
	function automatic logic hiMatch(input logic [INSTR_W-1:0] w,
		input logic [7:0] opc);
		hiMatch = (w[INSTR_W-1:COUNT_W] == opc);
	endfunction

	assign isRepMem = instrValid && hiMatch(instrWord, OPC_REPEAT_MEM);
	assign isRepImm = instrValid && hiMatch(instrWord, OPC_REPEAT_IMM);
	// memory form takes the low byte; immediate form the low field
	assign loadValue = isRepMem ? memOperand[COUNT_W-1:0]
		: instrWord[COUNT_W-1:0];

	// sequencer: armed after a repeat, repeating while count above zero
	always_ff @(posedge ref_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
			state_reg <= RFC_IDLE;
		else
		begin
			case (state_reg)
				RFC_IDLE:
					if (isRepMem || isRepImm)
						state_reg <= RFC_ARMED;
				RFC_ARMED:
					if (instrValid)
					begin
						// non-repeatable follower runs once only
						if (instrRepeatable && iteration_count_reg != COUNT_RESET)
							state_reg <= RFC_REPEAT;
						else
							state_reg <= RFC_IDLE;
					end
				RFC_REPEAT:
					if (iteration_count_reg == COUNT_ONE)
						state_reg <= RFC_IDLE;
				default:
					state_reg <= RFC_IDLE;
			endcase
		end
	end

	// iteration counter; counts down once per extra execution
	always_ff @(posedge ref_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
			iteration_count_reg <= COUNT_RESET;
		else if (state_reg == RFC_IDLE && (isRepMem || isRepImm))
			iteration_count_reg <= loadValue;
		else if (state_reg == RFC_ARMED && instrValid && !instrRepeatable)
			iteration_count_reg <= COUNT_RESET;
		else if (state_reg == RFC_ARMED && instrValid)
			iteration_count_reg <= iteration_count_reg; // first run, no step
		else if (state_reg == RFC_REPEAT)
			iteration_count_reg <= iteration_count_reg - COUNT_ONE;
	end

	// reissue pulse tells the core to run the held instruction again
	always_ff @(posedge ref_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
			reissue_reg <= 1'b0;
		else
			// last pass drops the request so the total is count plus one
			reissue_reg <= (state_reg == RFC_REPEAT &&
				iteration_count_reg != COUNT_ONE) ||
				(state_reg == RFC_ARMED && instrValid && instrRepeatable &&
				iteration_count_reg != COUNT_RESET);
	end

	// interrupt hold-off: the counter is not saved on a context switch
	always_ff @(posedge ref_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
			intMask_reg <= 1'b0;
		else if (state_reg == RFC_IDLE && (isRepMem || isRepImm))
			intMask_reg <= 1'b1;
		else if (state_reg == RFC_ARMED && instrValid &&
			!(instrRepeatable && iteration_count_reg != COUNT_RESET))
			intMask_reg <= 1'b0;
		else if (state_reg == RFC_REPEAT && iteration_count_reg == COUNT_ONE)
			intMask_reg <= 1'b0;
	end

	// test/control flag; clear instruction wins over a set
	always_ff @(posedge ref_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
			test_control_flag <= TC_RESET;
		else if (instrValid && instrWord == OPC_CLEAR_TC)
			test_control_flag <= 1'b0;
		else if (tcSet)
			test_control_flag <= 1'b1;
	end

	// transmit framing mode and frame sync pin direction
	always_ff @(posedge ref_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
		begin
			transmit_framing_mode_bit <= TXM_RESET;
			fsxOutEn_n_reg <= 1'b1;
		end
		else if (instrValid && instrWord == OPC_CLEAR_TXM)
		begin
			transmit_framing_mode_bit <= 1'b0;
			fsxOutEn_n_reg <= 1'b1;
		end
		else if (txmSet)
		begin
			transmit_framing_mode_bit <= 1'b1;
			fsxOutEn_n_reg <= 1'b0;
		end
	end

	// checks
	property p_loadMem;
		@(posedge ref_clk) disable iff (!rstSync_n)
		(state_reg == RFC_IDLE && isRepMem) |=>
			iteration_count_reg == $past(memOperand[COUNT_W-1:0]);
	endproperty
	a_loadMem: assert property (p_loadMem) else $error("mem load");

	property p_loadImm;
		@(posedge ref_clk) disable iff (!rstSync_n)
		(state_reg == RFC_IDLE && isRepImm) |=>
			iteration_count_reg == $past(instrWord[COUNT_W-1:0]);
	endproperty
	a_loadImm: assert property (p_loadImm) else $error("imm load");

	property p_repTwo;
		@(posedge ref_clk) disable iff (!rstSync_n)
		(state_reg == RFC_ARMED && instrValid && instrRepeatable &&
			iteration_count_reg == COUNT_ONE) |=>
			reissue_reg ##1 !reissue_reg;
	endproperty
	a_repTwo: assert property (p_repTwo) else $error("repeat count");

	property p_repStep;
		@(posedge ref_clk) disable iff (!rstSync_n)
		(state_reg == RFC_REPEAT) |=>
			iteration_count_reg == $past(iteration_count_reg) - COUNT_ONE;
	endproperty
	a_repStep: assert property (p_repStep) else $error("count step");

	property p_maskCover;
		@(posedge ref_clk) disable iff (!rstSync_n)
		reissue_reg |-> intMask_reg;
	endproperty
	a_maskCover: assert property (p_maskCover) else $error("mask gap");

	property p_maskHeld;
		@(posedge ref_clk) disable iff (!rstSync_n)
		(state_reg != RFC_IDLE) |-> intMask_reg;
	endproperty
	a_maskHeld: assert property (p_maskHeld) else $error("int mask");

	property p_maskEnd;
		@(posedge ref_clk) disable iff (!rstSync_n)
		$fell(intMask_reg) |-> state_reg == RFC_IDLE && !reissue_reg ##0
			$past(state_reg) != RFC_IDLE;
	endproperty
	a_maskEnd: assert property (p_maskEnd) else $error("mask end");

	property p_resetClr;
		@(posedge ref_clk)
		$rose(rstSync_n) |-> iteration_count_reg == COUNT_RESET;
	endproperty
	a_resetClr: assert property (p_resetClr) else $error("reset cnt");

	property p_tcClr;
		@(posedge ref_clk) disable iff (!rstSync_n)
		(instrValid && instrWord == OPC_CLEAR_TC) |=> !test_control_flag;
	endproperty
	a_tcClr: assert property (p_tcClr) else $error("tc clear");

	property p_txmClr;
		@(posedge ref_clk) disable iff (!rstSync_n)
		(instrValid && instrWord == OPC_CLEAR_TXM) |=>
			!transmit_framing_mode_bit && fsxOutEn_n_reg;
	endproperty
	a_txmClr: assert property (p_txmClr) else $error("txm clear");
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the repeat and flag-clear execution block
`timescale 1ns/100ps
`default_nettype none
module tb
	import rfc_pkg::*;
;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic instrValid = 1'b0;
	logic [INSTR_W-1:0] instrWord = 16'h0000;
	logic instrRepeatable = 1'b0;
	logic [INSTR_W-1:0] memOperand = 16'h0000;
	logic tcSet = 1'b0;
	logic txmSet = 1'b0;
	logic [COUNT_W-1:0] cnt;
	logic reissue, intMask, tcFlag, txmBit, fsxOeN;
	int bad_count = 0;
	int tests_run = 0;

	rfc_exec rfc_exec_i (.ref_clk(ref_clk), .reset_n(reset_n),
		.instrValid(instrValid), .instrWord(instrWord),
		.instrRepeatable(instrRepeatable), .memOperand(memOperand),
		.tcSet(tcSet), .txmSet(txmSet), .iteration_count_reg(cnt),
		.reissue_reg(reissue), .intMask_reg(intMask),
		.test_control_flag(tcFlag), .transmit_framing_mode_bit(txmBit),
		.fsxOutEn_n_reg(fsxOeN));

	// free-running core clock
	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp,
		input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one instruction, valid for exactly one sampling edge
	task automatic issue(input logic [15:0] w, input logic [15:0] m,
		input logic r);
		@(posedge ref_clk);
		instrValid <= 1'b1;
		instrWord <= w;
		memOperand <= m;
		instrRepeatable <= r;
		@(posedge ref_clk);
		instrValid <= 1'b0;
	endtask

	// repeat then follower; counts reissue cycles until the mask drops
	task automatic run_rep(input logic [15:0] w, input logic [15:0] m,
		input logic r, input logic [7:0] n);
		int reps;
		int k;
		reps = 0;
		issue(w, m, 1'b0);
		#1;
		chk("mask raised", 8'h01, 8'(intMask));
		chk("count loaded", n, cnt);
		issue(16'h1234, 16'h0000, r);
		#1;
		if (r)
			chk("count kept", n, cnt);
		// first reissue cycle already stands here, so count before waiting
		for (k = 0; k < 300 && (intMask === 1'b1 || reissue === 1'b1); k++)
		begin
			if (reissue === 1'b1)
				reps++;
			if (reissue === 1'b1)
				chk("mask during reissue", 8'h01, 8'(intMask));
			@(posedge ref_clk);
			#1;
		end
		chk("mask released", 8'h00, 8'(intMask));
		chk("reissue cycles", r ? n : 8'h00, 8'(reps));
		chk("count drained", 8'h00, cnt);
	endtask

	// set both flags, then clear each; clear beats a same-edge set
	task automatic flag_clears;
		@(posedge ref_clk);
		tcSet <= 1'b1;
		txmSet <= 1'b1;
		@(posedge ref_clk);
		tcSet <= 1'b0;
		txmSet <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk("tc set", 8'h01, 8'(tcFlag));
		chk("fsx driven", 8'h00, 8'(fsxOeN));
		@(posedge ref_clk);
		instrValid <= 1'b1;
		instrWord <= OPC_CLEAR_TC;
		tcSet <= 1'b1;
		@(posedge ref_clk);
		instrValid <= 1'b0;
		tcSet <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk("tc cleared", 8'h00, 8'(tcFlag));
		chk("txm kept", 8'h01, 8'(txmBit));
		@(posedge ref_clk);
		instrValid <= 1'b1;
		instrWord <= OPC_CLEAR_TXM;
		txmSet <= 1'b1;
		@(posedge ref_clk);
		instrValid <= 1'b0;
		txmSet <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk("txm cleared", 8'h00, 8'(txmBit));
		chk("fsx released", 8'h01, 8'(fsxOeN));
	endtask

	// reset arriving in mid-repeat must empty the counter at once
	task automatic mid_reset;
		issue({OPC_REPEAT_MEM, 8'h00}, 16'hFF10, 1'b0);
		issue(16'h1234, 16'h0000, 1'b1);
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b0;
		#1;
		chk("count after reset", COUNT_RESET, cnt);
		chk("mask after reset", 8'h00, 8'(intMask));
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge ref_clk);
		#1;
		chk("count after release", COUNT_RESET, cnt);
	endtask

	// main sequence; released reset needs the sync flops to settle
	initial
	begin
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge ref_clk);
		#1;
		chk("count at reset", COUNT_RESET, cnt);
		chk("fsx at reset", 8'h01, 8'(fsxOeN));
		run_rep({OPC_REPEAT_IMM, 8'h02}, 16'h0000, 1'b1, 8'h02);
		run_rep({OPC_REPEAT_IMM, 8'h01}, 16'h0000, 1'b1, 8'h01);
		run_rep({OPC_REPEAT_IMM, 8'h00}, 16'h0000, 1'b1, 8'h00);
		run_rep({OPC_REPEAT_IMM, 8'hFF}, 16'h0000, 1'b1, 8'hFF);
		run_rep({OPC_REPEAT_MEM, 8'h11}, 16'hA503, 1'b1, 8'h03);
		run_rep({OPC_REPEAT_IMM, 8'h05}, 16'h0000, 1'b0, 8'h05);
		flag_clears;
		mid_reset;
		test_done;
	end

	// hang guard, far beyond the few hundred cycles the run needs
	initial
	begin
		#200000;
		bad_count++;
		test_done;
	end
endmodule
`default_nettype wire
